// ---- hdl/wosr_lv_filter.sv ----
/* wosr_lv_filter: debounce of the low-voltage trip and hold of the
   resulting reset until the supply is back.
   assumes detector trip inputs synchronous to clk_i. */
`timescale 1ns/1ps
module wosr_lv_filter
   import wosr_pkg::*;
(
   input  wire logic clk_i,        // system clock
   input  wire logic rst_i,        // sync reset, high
   input  wire logic enable_i,     // detector powered and active
   input  wire logic below_fall_i, // supply at or below falling trip
   input  wire logic at_rise_i,    // supply reached rising trip
   output logic      request_o     // reset request, held
);
   // =====================================================
   // declarations
   logic [3:0] cnt_reg;  // consecutive low cycles seen
   logic       hold_reg; // request latched

   // =====================================================
   // consecutive-cycle counter and hold
   always_ff @(posedge clk_i) begin
      if (rst_i || !enable_i) begin
         cnt_reg  <= 4'h0;  // dead detector reports nothing
         hold_reg <= 1'b0;
      end else if (hold_reg) begin
         cnt_reg <= 4'h0;
         if (at_rise_i) begin
            hold_reg <= 1'b0;
         end
      end else if (below_fall_i) begin
         // a glitch shorter than the window never resets the part
         if (cnt_reg == 4'(LV_FILT_CYC - 1)) begin
            hold_reg <= 1'b1;
         end else begin
            cnt_reg <= cnt_reg + 4'h1;
         end
      end else begin
         cnt_reg <= 4'h0;  // run broken, start over
      end
   end

   assign request_o = hold_reg;

   // =====================================================
   // checks
   nine_low_a: assert property (@(posedge clk_i) disable iff (rst_i)
      (enable_i && below_fall_i && !hold_reg)[*8] ##1
      (enable_i && below_fall_i && !hold_reg) |=> hold_reg)
      else $error("reset not issued after nine low cycles");
   no_early_a: assert property (@(posedge clk_i) disable iff (rst_i)
      $rose(hold_reg) |-> $past(cnt_reg) == 4'h8)
      else $error("reset issued before nine low cycles");
   hold_until_a: assert property (@(posedge clk_i) disable iff (rst_i)
      hold_reg && enable_i && !at_rise_i |=> hold_reg)
      else $error("reset released before supply recovered");

endmodule // wosr_lv_filter

// ---- hdl/wosr_stop_recovery.sv ----
/* wosr_stop_recovery: counts crystal ticks after a stop wake-up and
   reports when the chosen recovery delay has run out.
   assumes xtal_tick_i is a one-cycle enable at the crystal rate. */
`timescale 1ns/1ps
module wosr_stop_recovery
   import wosr_pkg::*;
(
   input  wire logic clk_i,       // system clock
   input  wire logic rst_i,       // sync reset, high
   input  wire logic xtal_tick_i, // crystal-rate enable
   input  wire logic start_i,     // wake-up seen, pulse
   input  wire logic short_i,     // short recovery selected
   output logic      busy_o,      // delay running
   output logic      done_o       // delay over, pulse
);
   // =====================================================
   // declarations
   logic [11:0] cnt_reg;  // ticks counted
   logic [11:0] last_reg; // terminal count, latched at start
   logic        busy_reg; // counting
   logic        done_reg; // end pulse

   // =====================================================
   // delay counter; length frozen at start
   always_ff @(posedge clk_i) begin
      done_reg <= 1'b0;
      if (rst_i) begin
         cnt_reg  <= 12'h000;
         last_reg <= 12'h000;
         busy_reg <= 1'b0;
      end else if (start_i && !busy_reg) begin
         cnt_reg  <= 12'h000;
         busy_reg <= 1'b1;
         last_reg <= short_i ? 12'(RECOV_SHORT_CYC - 1)
                             : 12'(RECOV_LONG_CYC - 1);
      end else if (busy_reg && xtal_tick_i) begin
         if (cnt_reg == last_reg) begin
            busy_reg <= 1'b0;
            done_reg <= 1'b1;
         end else begin
            cnt_reg <= cnt_reg + 12'h001;
         end
      end
   end

   assign busy_o = busy_reg;
   assign done_o = done_reg;

   // =====================================================
   // checks
   recov_len_a: assert property (@(posedge clk_i) disable iff (rst_i)
      done_reg |-> $past(cnt_reg) == $past(last_reg) && $past(xtal_tick_i))
      else $error("stop recovery ended at wrong count");
   recov_sel_a: assert property (@(posedge clk_i) disable iff (rst_i)
      start_i && !busy_reg |=> last_reg == ($past(short_i) ? 12'h01f : 12'hfff))
      else $error("stop recovery length not as selected");

endmodule // wosr_stop_recovery

// ---- hdl/wosr_top.sv ----
/* wosr_top: write-once system option register with the option logic
   it steers: low-voltage detector gating, stop sequencing with
   recovery delay, watchdog timeout and stop-instruction check.
   assumes a classic wishbone master on the register side, cpu event
   inputs synchronous to clk_i, and that rst_i is pulsed by whatever
   system reset source exists, the low-voltage reset among them. */
// Our own choices: register access over Wishbone and the register addresses.
`timescale 1ns/1ps
module wosr_top
   import wosr_pkg::*;
#(
   parameter int WDOG_SHORT = WDOG_SHORT_CYC, // short watchdog timeout
   parameter int WDOG_LONG  = WDOG_LONG_CYC   // long watchdog timeout
)
(
   input  wire logic        clk_i,                     // 200 MHz clock
   input  wire logic        rst_i,                     // sync reset, high
   // wishbone slave
   input  wire logic        cyc_i,                     // bus cycle
   input  wire logic        stb_i,                     // strobe
   input  wire logic        we_i,                      // write enable
   input  wire logic [7:0]  adr_i,                     // byte address
   input  wire logic [3:0]  sel_i,                     // byte lanes
   input  wire logic [31:0] dat_i,                     // write data
   output logic      [31:0] dat_o,                     // read data
   output logic             ack_o,                     // acknowledge
   // cpu and analog side events
   input  wire logic        stop_instr_i,              // stop executed
   input  wire logic        stop_wake_i,               // wake from stop
   input  wire logic        supply_below_fall_i,       // trip low
   input  wire logic        supply_at_rise_i,          // trip recovered
   input  wire logic        watchdog_service_i,        // watchdog kick
   // static option outputs
   output logic             detector_stop_enable_o,    // option bit
   output logic             detector_reset_enable_o,   // option bit
   output logic             detector_power_enable_o,   // option bit
   output logic             short_recovery_select_o,   // option bit
   output logic             watchdog_short_timeout_o,  // option bit
   output logic             watchdog_disable_o,        // option bit
   output logic             stop_enable_o,             // option bit
   // derived controls and events
   output logic             detector_active_o,         // detector running
   output logic             low_voltage_reset_o,       // reset request
   output logic             watchdog_reset_o,          // timeout pulse
   output logic             stop_mode_o,               // clocks stopped
   output logic             stop_illegal_o             // illegal op pulse
);
   // =====================================================
   // declarations
   logic [7:0]  opt_reg;       // stored options
   logic        locked_reg;    // first write taken
   logic        ack_reg;       // bus answer
   logic [31:0] rdat_reg;      // read data
   logic [7:0]  div_reg;       // crystal divider
   logic        tick_reg;      // crystal-rate enable
   logic [17:0] wd_cnt_reg;    // watchdog count
   logic [17:0] wd_last;       // watchdog terminal count
   logic        wd_rst_reg;    // watchdog timeout pulse
   logic        illegal_reg;   // illegal opcode pulse
   logic        active_reg;    // detector active
   logic        lvr_reg;       // gated low-voltage reset
   wosr_stop_t  state_reg;     // stop sequencer state
   wosr_stop_t  state_next;    // its next value
   logic        bus_req;       // new request this cycle
   logic        opt_wr;        // option write accepted
   logic        lv_request;    // filtered detector request
   logic        lv_enable;     // detector powered and running
   logic        recov_start;   // begin recovery delay
   logic        recov_busy;    // recovery delay running
   logic        recov_done;    // recovery delay over
   logic        active_next;   // detector active, next

   // =====================================================
   // helpers
   // option write data, reserved bit kept zero
   function automatic logic [7:0] opt_merge(input logic [7:0] d);
      return d & OPT_WMASK;
   endfunction

   // read mux shared by bus logic
   function automatic logic [31:0] read_mux(input logic [7:0] a);
      logic [31:0] r;
      r = 32'h0000_0000;
      if (a == OPT_ADR) begin
         r[7:0] = opt_reg;
      end else if (a == STAT_ADR) begin
         r[STAT_LOCK] = locked_reg;
         r[STAT_STOP] = (state_reg == ST_STOP);
         r[STAT_RECV] = recov_busy;
         r[STAT_LVR]  = lvr_reg;
      end
      return r;  // unmapped reads return zero
   endfunction

   // =====================================================
   // wishbone slave: one wait state, ack for one cycle
   assign bus_req = cyc_i && stb_i && !ack_reg;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_reg  <= 1'b0;
         rdat_reg <= 32'h0000_0000;
      end else begin
         ack_reg <= bus_req;  // unmapped addresses are acked too
         if (bus_req && !we_i) begin
            rdat_reg <= read_mux(adr_i);
         end
      end
   end

   assign ack_o = ack_reg;
   assign dat_o = rdat_reg;

   // =====================================================
   // write-once option register
   // only lane 0 carries the byte; a write without it is no write
   assign opt_wr = bus_req && we_i && (adr_i == OPT_ADR) && sel_i[0]
                   && !locked_reg;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         opt_reg    <= OPT_RESET;
         locked_reg <= 1'b0;       // reset unlocks
      end else if (opt_wr) begin
         opt_reg    <= opt_merge(dat_i[7:0]);
         locked_reg <= 1'b1;
      end
   end

   // static option outputs straight from the flops
   assign detector_stop_enable_o   = opt_reg[OPT_LVSTOP];
   assign detector_reset_enable_o  = opt_reg[OPT_RSTEN];
   assign detector_power_enable_o  = opt_reg[OPT_PWR];
   assign short_recovery_select_o  = opt_reg[OPT_SREC];
   assign watchdog_short_timeout_o = opt_reg[OPT_WSHORT];
   assign watchdog_disable_o       = opt_reg[OPT_WDIS];
   assign stop_enable_o            = opt_reg[OPT_STOPEN];

   // =====================================================
   // crystal-rate enable from the system clock
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         div_reg  <= 8'h00;
         tick_reg <= 1'b0;
      end else if (div_reg == 8'(XTAL_DIV - 1)) begin
         div_reg  <= 8'h00;
         tick_reg <= 1'b1;
      end else begin
         div_reg  <= div_reg + 8'h01;
         tick_reg <= 1'b0;
      end
   end

   // =====================================================
   // stop sequencer
   always_comb begin
      state_next  = state_reg;
      recov_start = 1'b0;
      case (state_reg)
         ST_RUN: begin
            if (stop_instr_i && opt_reg[OPT_STOPEN]) begin
               state_next = ST_STOP;
            end
         end
         ST_STOP: begin
            if (stop_wake_i) begin
               state_next  = ST_RECOVER;
               recov_start = 1'b1;
            end
         end
         ST_RECOVER: begin
            if (recov_done) begin
               state_next = ST_RUN;
            end
         end
         default: begin
            state_next = ST_RUN;
         end
      endcase
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         state_reg <= ST_RUN;
      end else begin
         state_reg <= state_next;
      end
   end

   // illegal opcode report when stop is not allowed
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         illegal_reg <= 1'b0;
      end else begin
         illegal_reg <= (state_reg == ST_RUN) && stop_instr_i
                        && !opt_reg[OPT_STOPEN];
      end
   end

   assign stop_mode_o    = (state_reg != ST_RUN);
   assign stop_illegal_o = illegal_reg;

   wosr_stop_recovery u_recovery (
      .clk_i       (clk_i),
      .rst_i       (rst_i),
      .xtal_tick_i (tick_reg),
      .start_i     (recov_start),
      .short_i     (opt_reg[OPT_SREC]),
      .busy_o      (recov_busy),
      .done_o      (recov_done)
   );

   // =====================================================
   // low-voltage detector gating
   // in stop the detector only stays up if both bits allow it;
   // that costs stop current, which is why it is optional
   assign active_next = opt_reg[OPT_PWR]
                        && (state_reg != ST_STOP
                            || opt_reg[OPT_LVSTOP]);
   assign lv_enable   = active_reg;

   wosr_lv_filter u_lv_filter (
      .clk_i        (clk_i),
      .rst_i        (rst_i),
      .enable_i     (lv_enable),
      .below_fall_i (supply_below_fall_i),
      .at_rise_i    (supply_at_rise_i),
      .request_o    (lv_request)
   );

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         active_reg <= 1'b0;
         lvr_reg    <= 1'b0;
      end else begin
         active_reg <= active_next;
         lvr_reg    <= lv_request && opt_reg[OPT_RSTEN];
      end
   end

   assign detector_active_o   = active_reg;
   assign low_voltage_reset_o = lvr_reg;

   // =====================================================
   // watchdog timeout counter in crystal cycles
   // counter is frozen in stop; the crystal does not run there
   assign wd_last = opt_reg[OPT_WSHORT] ? 18'(WDOG_SHORT - 1)
                                        : 18'(WDOG_LONG - 1);

   always_ff @(posedge clk_i) begin
      wd_rst_reg <= 1'b0;
      if (rst_i || opt_reg[OPT_WDIS] || watchdog_service_i) begin
         wd_cnt_reg <= 18'h00000;
      end else if (tick_reg && state_reg == ST_RUN) begin
         if (wd_cnt_reg >= wd_last) begin
            wd_cnt_reg <= 18'h00000;
            wd_rst_reg <= 1'b1;
         end else begin
            wd_cnt_reg <= wd_cnt_reg + 18'h00001;
         end
      end
   end

   assign watchdog_reset_o = wd_rst_reg;

   // =====================================================
   // checks
   write_once_a: assert property (
      @(posedge clk_i) disable iff (rst_i)
      locked_reg |=> $stable(opt_reg))
      else $error("option register changed after lock");

   first_write_a: assert property (
      @(posedge clk_i) disable iff (rst_i)
      opt_wr |=> locked_reg && opt_reg == ($past(dat_i[7:0]) & 8'hbf)
                 && watchdog_disable_o == $past(dat_i[0]))
      else $error("first write not stored");

   default_read_a: assert property (
      @(posedge clk_i) disable iff (rst_i)
      bus_req && !we_i && adr_i == 8'h00 && !locked_reg
      |=> ack_o && dat_o == 32'h0000_0030)
      else $error("default not read before first write");

   stop_gate_a: assert property (
      @(posedge clk_i) disable iff (rst_i)
      state_reg == ST_STOP && $stable(state_reg)
      |=> detector_active_o == $past(opt_reg[4] && opt_reg[7]))
      else $error("detector state in stop wrong");

   // a held request needs two more cycles to drain through the filter and lvr_reg
   power_off_a: assert property (
      @(posedge clk_i) disable iff (rst_i)
      !opt_reg[OPT_PWR] |=> !detector_active_o ##2 !low_voltage_reset_o)
      else $error("unpowered detector active");

   reset_gate_a: assert property (
      @(posedge clk_i) disable iff (rst_i)
      !opt_reg[OPT_RSTEN] |=> !low_voltage_reset_o)
      else $error("blocked detector reset passed");

   wd_off_a: assert property (
      @(posedge clk_i) disable iff (rst_i)
      opt_reg[OPT_WDIS] |=> !watchdog_reset_o && wd_cnt_reg == 18'h00000)
      else $error("disabled watchdog running");

   wd_len_a: assert property (
      @(posedge clk_i) disable iff (rst_i)
      wd_rst_reg |-> $past(wd_cnt_reg) == $past(wd_last) && $past(tick_reg))
      else $error("watchdog timeout at wrong count");

   illegal_stop_a: assert property (
      @(posedge clk_i) disable iff (rst_i)
      state_reg == ST_RUN && stop_instr_i && !opt_reg[OPT_STOPEN]
      |=> stop_illegal_o && !stop_mode_o)
      else $error("disabled stop not treated as illegal");

   // =====================================================
   // further checks on lock, bus, stop sequencing and gating
   lock_stays_a: assert property (
      @(posedge clk_i) disable iff (rst_i)
      locked_reg |=> locked_reg)
      else $error("lock dropped without reset");

   ack_pulse_a: assert property (
      @(posedge clk_i) disable iff (rst_i)
      ack_o |=> !ack_o)
      else $error("bus answer longer than one cycle");

   stop_entry_a: assert property (
      @(posedge clk_i) disable iff (rst_i)
      state_reg == ST_RUN && stop_instr_i && opt_reg[OPT_STOPEN]
      |=> stop_mode_o && !stop_illegal_o)
      else $error("enabled stop not entered");

   // wake must start the delay, and the delay must gate the exit
   wake_start_a: assert property (
      @(posedge clk_i) disable iff (rst_i)
      state_reg == ST_STOP && stop_wake_i |=> recov_busy)
      else $error("wake did not start recovery");

   stop_hold_a: assert property (
      @(posedge clk_i) disable iff (rst_i)
      state_reg == ST_RECOVER && !recov_done |=> stop_mode_o)
      else $error("stop left before recovery delay");

   recov_exit_a: assert property (
      @(posedge clk_i) disable iff (rst_i)
      state_reg == ST_RECOVER && recov_done |=> !stop_mode_o)
      else $error("stop not left after recovery delay");

   run_power_a: assert property (
      @(posedge clk_i) disable iff (rst_i)
      state_reg != ST_STOP
      |=> detector_active_o == $past(opt_reg[OPT_PWR]))
      else $error("detector power not following option");

   lvr_pass_a: assert property (
      @(posedge clk_i) disable iff (rst_i)
      lv_request && opt_reg[OPT_RSTEN] |=> low_voltage_reset_o)
      else $error("enabled detector reset not passed");

endmodule // wosr_top

// ---- inc/wosr_pkg.sv ----
/* wosr_pkg: constants, bit layout and state type for the write-once
   system option register block.
   assumes a single 200 MHz system clock and a crystal rate that is a
   whole divisor of it. */
// What this block does
// - first write after reset sticks; later writes ignored
// - reads before first write return default
// - low-voltage reset after nine low cycles
// - hold low-voltage reset until supply recovers
// - stop-enable bit keeps detector alive in stop
// - detector alive in stop needs power and stop-enable
// - reset-enable bit gates detector reset request
// - power bit powers the low-voltage detector
// - stop recovery is 32 or 4096 crystal cycles
// - watchdog timeout length chosen by option bit
// - stop disabled means stop is illegal opcode
// - watchdog disable bit turns watchdog off
package wosr_pkg;

   // =====================================================
   // clocking
   localparam int CLK_HZ   = 200_000_000;  // system clock
   localparam int XTAL_HZ  = 8_000_000;    // crystal rate, plain default
   localparam int XTAL_DIV = CLK_HZ / XTAL_HZ; // clk cycles per tick

   // =====================================================
   // register map (byte addresses)
   localparam logic [7:0] OPT_ADR  = 8'h00; // option register
   localparam logic [7:0] STAT_ADR = 8'h04; // status register

   // =====================================================
   // option register fields
   localparam int OPT_WDIS   = 0; // watchdog disable
   localparam int OPT_STOPEN = 1; // stop instruction enable
   localparam int OPT_WSHORT = 2; // watchdog short timeout
   localparam int OPT_SREC   = 3; // short recovery select
   localparam int OPT_PWR    = 4; // detector power enable
   localparam int OPT_RSTEN  = 5; // detector reset enable
   localparam int OPT_LVSTOP = 7; // detector stop enable
   localparam logic [7:0] OPT_RESET = 8'h30; // default value
   localparam logic [7:0] OPT_WMASK = 8'hbf; // bit 6 reserved

   // =====================================================
   // status register fields
   localparam int STAT_LOCK = 0; // option register locked
   localparam int STAT_STOP = 1; // in stop mode
   localparam int STAT_RECV = 2; // stop recovery running
   localparam int STAT_LVR  = 3; // low-voltage reset asserted

   // =====================================================
   // cycle counts
   localparam int LV_FILT_CYC     = 9;    // cpu cycles below trip
   localparam int RECOV_SHORT_CYC = 32;   // crystal cycles
   localparam int RECOV_LONG_CYC  = 4096; // crystal cycles
   localparam int WDOG_SHORT_CYC  = 2**13 - 2**4; // crystal cycles
   localparam int WDOG_LONG_CYC   = 2**18 - 2**4; // crystal cycles

   // =====================================================
   // stop sequencing, gray along run -> stop -> recover
   typedef enum logic [1:0] {
      ST_RUN     = 2'b00,
      ST_STOP    = 2'b01,
      ST_RECOVER = 2'b11
   } wosr_stop_t;

endpackage

// ---- verification/wosr_top_test.sv ----
/* wosr_top_test: self-checking bench for the option register block.
   assumes the wosr_pkg constants and the one-cycle wishbone ack. */
`timescale 1ns/1ps
module wosr_top_test
   import wosr_pkg::*;
;
   // ==========================================================
   // signals
   localparam int WS = 20; // shortened watchdog counts
   localparam int WL = 40;
   logic        clk_i = 1'b0, rst_i = 1'b1, cyc_i = 1'b0, stb_i = 1'b0;
   logic        we_i = 1'b0, stop_instr_i = 1'b0, stop_wake_i = 1'b0;
   logic        supply_below_fall_i = 1'b0, supply_at_rise_i = 1'b0;
   logic        watchdog_service_i = 1'b0;
   logic [7:0]  adr_i = 8'h00;
   logic [3:0]  sel_i = 4'h0;
   logic [31:0] dat_i = 32'h0, dat_o, q;
   logic        ack_o, lvstop, rsten, pwr, srec, wshort, wdis, stopen;
   logic        active, lvr, wdog, stop_mode, illegal, seen;
   int          bad_count = 0, n_checks = 0, n;
   wire  [7:0]  opt_seen = {lvstop, 1'b0, rsten, pwr, srec, wshort,
                            stopen, wdis}; // outputs in register layout
   typedef struct { logic [7:0] wr; logic [7:0] exp; } wosr_row_t;
   wosr_row_t   rows [4] = '{'{8'hff, 8'hbf}, '{8'h00, 8'h00},
                             '{8'ha5, 8'ha5}, '{8'h5a, 8'h1a}};

   always #2.5 clk_i = ~clk_i; // 200 MHz

   wosr_top #(.WDOG_SHORT(WS), .WDOG_LONG(WL)) dut (
      .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
      .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i),
      .dat_o(dat_o), .ack_o(ack_o), .stop_instr_i(stop_instr_i),
      .stop_wake_i(stop_wake_i), .supply_below_fall_i(supply_below_fall_i),
      .supply_at_rise_i(supply_at_rise_i),
      .watchdog_service_i(watchdog_service_i),
      .detector_stop_enable_o(lvstop), .detector_reset_enable_o(rsten),
      .detector_power_enable_o(pwr), .short_recovery_select_o(srec),
      .watchdog_short_timeout_o(wshort), .watchdog_disable_o(wdis),
      .stop_enable_o(stopen), .detector_active_o(active),
      .low_voltage_reset_o(lvr), .watchdog_reset_o(wdog),
      .stop_mode_o(stop_mode), .stop_illegal_o(illegal));

   // ==========================================================
   // helpers
   task automatic complete_run;
      $display("checks %0d mismatches %0d", n_checks, bad_count);
      if (bad_count == 0 && n_checks > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         bad_count++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // classic cycle: hold until ack sampled, then one idle cycle
   task automatic wb(input logic w, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] r);
      int k;
      cyc_i <= 1'b1;
      stb_i <= 1'b1;
      we_i  <= w;
      adr_i <= a;
      dat_i <= d;
      sel_i <= 4'hf;
      k = 0;
      do begin
         @(posedge clk_i);
         k++;
      end while (ack_o !== 1'b1 && k < 50);
      if (k >= 50) begin
         bad_count++;
         complete_run();
      end
      r = dat_o;
      cyc_i <= 1'b0;
      stb_i <= 1'b0;
      @(posedge clk_i);
   endtask

   task automatic do_reset;
      rst_i <= 1'b1;
      repeat (3) @(posedge clk_i);
      rst_i <= 1'b0;
      repeat (2) @(posedge clk_i);
   endtask

   task automatic setup(input logic [7:0] v); // reset, then the one write
      do_reset();
      wb(1'b1, OPT_ADR, {24'h0, v}, q);
   endtask

   // cycles until watchdog pulse (sel 0) or stop mode ends (sel 1)
   task automatic wait_for(input int sel, output int c);
      c = 0;
      while (c < 3000 && !(sel == 0 ? wdog === 1'b1 : stop_mode === 1'b0))
      begin
         @(posedge clk_i);
         c++;
      end
      if (c >= 3000) begin
         bad_count++;
         complete_run();
      end
   endtask

   // tick phase makes counts uncertain by one crystal period
   function automatic logic [31:0] near(input int c, input int e);
      return 32'(c >= e - XTAL_DIV && c <= e + 5);
   endfunction

   task automatic pulse_stop;
      stop_instr_i <= 1'b1;
      @(posedge clk_i);
      stop_instr_i <= 1'b0;
      seen = 1'b0;
      repeat (3) begin
         @(posedge clk_i);
         seen = seen | (illegal === 1'b1);
      end
   endtask

   task automatic low_for(input int c); // supply below trip c cycles
      supply_below_fall_i <= 1'b1;
      repeat (c) @(posedge clk_i);
      supply_below_fall_i <= 1'b0;
      repeat (2) @(posedge clk_i);
   endtask

   // ==========================================================
   // main sequence
   initial begin
      foreach (rows[i]) begin
         do_reset();
         wb(1'b0, OPT_ADR, 32'h0, q);
         chk(q, {24'h0, OPT_RESET});
         wb(1'b1, OPT_ADR, {24'h0, rows[i].wr}, q);
         wb(1'b0, OPT_ADR, 32'h0, q);
         chk(q, {24'h0, rows[i].exp});
         chk(opt_seen, rows[i].exp);
         chk(active, rows[i].exp[4]);
         wb(1'b1, OPT_ADR, {24'h0, ~rows[i].wr}, q);
         wb(1'b0, OPT_ADR, 32'h0, q);
         chk(q, {24'h0, rows[i].exp});
         wb(1'b0, 8'h08, 32'h0, q);
         chk(q, 32'h0); // unmapped reads as zero
      end
      $display("test rows done");
      do_reset(); // default: stop refused, detector resets on
      pulse_stop();
      chk({stop_mode, seen}, 2'b01);
      low_for(8);
      chk(lvr, 1'b0);
      supply_below_fall_i <= 1'b1;
      repeat (12) @(posedge clk_i);
      chk(lvr, 1'b1);
      supply_below_fall_i <= 1'b0;
      repeat (4) @(posedge clk_i);
      chk(lvr, 1'b1);
      wb(1'b0, STAT_ADR, 32'h0, q);
      chk(q, 32'h0000_0008);
      supply_at_rise_i <= 1'b1;
      repeat (4) @(posedge clk_i);
      chk(lvr, 1'b0);
      supply_at_rise_i <= 1'b0;
      setup(8'h10); // powered, reset request blocked
      low_for(12);
      chk(lvr, 1'b0);
      $display("test detector done");
      setup(8'h9a); // short recovery, detector kept in stop
      pulse_stop();
      chk({stop_mode, active}, 2'b11);
      wb(1'b0, STAT_ADR, 32'h0, q);
      chk(q, 32'h0000_0003);
      stop_wake_i <= 1'b1;
      @(posedge clk_i);
      stop_wake_i <= 1'b0;
      wait_for(1, n);
      chk(near(n, RECOV_SHORT_CYC * XTAL_DIV), 1);
      setup(8'h12); // long recovery, detector off in stop
      pulse_stop();
      chk({stop_mode, active}, 2'b10);
      stop_wake_i <= 1'b1;
      @(posedge clk_i);
      stop_wake_i <= 1'b0;
      repeat (900) @(posedge clk_i);
      chk(stop_mode, 1'b1);
      $display("test stop done");
      for (int s = 0; s < 2; s++) begin
         setup(s == 1 ? 8'h34 : 8'h30);
         watchdog_service_i <= 1'b1;
         @(posedge clk_i);
         watchdog_service_i <= 1'b0;
         wait_for(0, n);
         chk(near(n, ((s == 1) ? WS : WL) * XTAL_DIV), 1);
      end
      setup(8'h31);
      seen = 1'b0;
      repeat (1200) begin
         @(posedge clk_i);
         seen = seen | (wdog === 1'b1);
      end
      chk(seen, 1'b0);
      $display("test watchdog done");
      complete_run();
   end
endmodule // wosr_top_test
